/* File: tmja_map.vh */
// Constants for the trace macrocell JTAG register access block
`ifndef TMJA_MAP_VH
`define TMJA_MAP_VH
`define TMJA_CHAIN_W        4
`define TMJA_CHAIN_NUM      4'h6
`define TMJA_DR_W           40
`define TMJA_DATA_LSB       0
`define TMJA_DATA_MSB       31
`define TMJA_ADDR_LSB       32
`define TMJA_ADDR_MSB       38
`define TMJA_RW_BIT         39
`define TMJA_IR_W           4
`define TMJA_IR_SCAN_N      4'h2
`define TMJA_IR_INTEST      4'hc
`define TMJA_IR_BYPASS      4'hf
`define TMJA_IR_RESET       4'he
`define TMJA_IR_CAPTURE     4'h1
`define TMJA_CHAIN_RESET    4'h0
`define TMJA_REG_DEPTH      128
`define TMJA_REG_RESET      32'h00000000
`endif

/* File: tmja_regfile.v */
// Trace macrocell register store, 128 words, registered read data
`timescale 1ns/1ps
module tmja_regfile (
  input  wire        clock_i,
  input  wire        wr_en_i,
  input  wire [6:0]  wr_addr_i,
  input  wire [31:0] wr_data_i,
  input  wire [6:0]  rd_addr_i,
  output reg  [31:0] rd_data_o
);
  reg [31:0] mem_reg [0:127];
  integer i;
  initial begin
    for (i = 0; i < 128; i = i + 1) begin
      mem_reg[i] = 32'h00000000;
    end
  end
  always @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_reg[rd_addr_i];
  end
endmodule // tmja_regfile

/* File: tmja_jtag_access.v */
// TAP controller with scan chain select and 40-bit trace register access chain
// Behaviour
// - Registers reachable only via TAP chain 6
// - Chain is 32 data, 7 address, 1 rw
// - Read requests never store the data field
// - Access happens only on entering Update-DR
`timescale 1ns/1ps
`include "tmja_map.vh"
module tmja_jtag_access (
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire        tck_i,
  input  wire        tms_i,
  input  wire        tdi_i,
  input  wire        trst_n_i,
  output reg         tdo_o,
  output reg         tdo_oe_n_o,
  output reg         wr_pulse_o,
  output reg  [6:0]  wr_addr_o,
  output reg  [31:0] wr_data_o
);
  // One-hot TAP states; any illegal code falls back to Test-Logic-Reset
  localparam [15:0] S_RESET = 16'h0001;
  localparam [15:0] S_IDLE  = 16'h0002;
  localparam [15:0] S_SELDR = 16'h0004;
  localparam [15:0] S_CAPDR = 16'h0008;
  localparam [15:0] S_SHDR  = 16'h0010;
  localparam [15:0] S_EX1DR = 16'h0020;
  localparam [15:0] S_PSDR  = 16'h0040;
  localparam [15:0] S_EX2DR = 16'h0080;
  localparam [15:0] S_UPDR  = 16'h0100;
  localparam [15:0] S_SELIR = 16'h0200;
  localparam [15:0] S_CAPIR = 16'h0400;
  localparam [15:0] S_SHIR  = 16'h0800;
  localparam [15:0] S_EX1IR = 16'h1000;
  localparam [15:0] S_PSIR  = 16'h2000;
  localparam [15:0] S_EX2IR = 16'h4000;
  localparam [15:0] S_UPIR  = 16'h8000;

  // Two-stage synchronisers; only the second stage is read by logic
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  // Edge detector resets low, the idle level of the test clock, so reset
  // release never shows a false rising edge
  reg       tck_last_reg;
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      sync1_reg    <= 4'h0;
      sync2_reg    <= 4'h0;
      tck_last_reg <= 1'b0;
    end else begin
      sync1_reg    <= {trst_n_i, tdi_i, tms_i, tck_i};
      sync2_reg    <= sync1_reg;
      tck_last_reg <= sync2_reg[0];
    end
  end
  wire tck_s   = sync2_reg[0];
  wire tms_s   = sync2_reg[1];
  wire tdi_s   = sync2_reg[2];
  wire trst_n_s = sync2_reg[3];
  wire tck_rise = tck_s & ~tck_last_reg;
  wire tck_fall = ~tck_s & tck_last_reg;

  // Shadows are split from live copies so shifting never disturbs a selection
  reg [15:0]                state_reg;
  reg [15:0]                state_next;
  reg [`TMJA_IR_W-1:0]      ir_sh_reg;
  reg [`TMJA_IR_W-1:0]      ir_reg;
  reg [`TMJA_CHAIN_W-1:0]   chain_sh_reg;
  reg [`TMJA_CHAIN_W-1:0]   chain_reg;
  reg [`TMJA_DR_W-1:0]      dr_reg;
  reg                       byp_reg;
  reg                       rd_pend_reg;
  reg [6:0]                 rd_addr_reg;
  wire [31:0]               rd_data;

  // Standard TAP walk, steered by the mode line at each rising test clock
  always @* begin
    case (state_reg)
      S_RESET: state_next = tms_s ? S_RESET : S_IDLE;
      S_IDLE:  state_next = tms_s ? S_SELDR : S_IDLE;
      S_SELDR: state_next = tms_s ? S_SELIR : S_CAPDR;
      S_CAPDR: state_next = tms_s ? S_EX1DR : S_SHDR;
      S_SHDR:  state_next = tms_s ? S_EX1DR : S_SHDR;
      S_EX1DR: state_next = tms_s ? S_UPDR  : S_PSDR;
      S_PSDR:  state_next = tms_s ? S_EX2DR : S_PSDR;
      S_EX2DR: state_next = tms_s ? S_UPDR  : S_SHDR;
      S_UPDR:  state_next = tms_s ? S_SELDR : S_IDLE;
      S_SELIR: state_next = tms_s ? S_RESET : S_CAPIR;
      S_CAPIR: state_next = tms_s ? S_EX1IR : S_SHIR;
      S_SHIR:  state_next = tms_s ? S_EX1IR : S_SHIR;
      S_EX1IR: state_next = tms_s ? S_UPIR  : S_PSIR;
      S_PSIR:  state_next = tms_s ? S_EX2IR : S_PSIR;
      S_EX2IR: state_next = tms_s ? S_UPIR  : S_SHIR;
      S_UPIR:  state_next = tms_s ? S_SELDR : S_IDLE;
      default: state_next = S_RESET;
    endcase
  end

  // TAP state advances only on a detected rising test clock edge
  always @(posedge clock_i) begin
    if (!rst_n_i || !trst_n_s) begin
      state_reg <= S_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // Trace chain is live only with INTEST selected and chain 6 latched
  wire trace_sel = (ir_reg == `TMJA_IR_INTEST) && (chain_reg == `TMJA_CHAIN_NUM);
  // Chain select register is shifted only while SCAN_N is loaded
  wire scan_sel  = (ir_reg == `TMJA_IR_SCAN_N);
  // The top bit of the chain tells a write from a read
  wire is_write  = dr_reg[`TMJA_RW_BIT];
  wire [6:0] dr_addr = dr_reg[`TMJA_ADDR_MSB:`TMJA_ADDR_LSB];
  // Access is keyed to the edge that enters Update-DR, never to shifting
  wire enter_upd = tck_rise && (state_next == S_UPDR) && (state_reg != S_UPDR);
  // Whichever chain the instruction selects feeds data out during Shift-DR
  wire dr_out_bit = trace_sel ? dr_reg[0] : (scan_sel ? chain_sh_reg[0] : byp_reg);

  always @(posedge clock_i) begin
    if (!rst_n_i || !trst_n_s) begin
      ir_sh_reg    <= `TMJA_IR_RESET;
      ir_reg       <= `TMJA_IR_BYPASS;
      chain_sh_reg <= `TMJA_CHAIN_RESET;
      chain_reg    <= `TMJA_CHAIN_RESET;
      dr_reg       <= {`TMJA_DR_W{1'b0}};
      byp_reg      <= 1'b0;
      rd_pend_reg  <= 1'b0;
      rd_addr_reg  <= 7'h00;
      wr_pulse_o   <= 1'b0;
      wr_addr_o    <= 7'h00;
      wr_data_o    <= `TMJA_REG_RESET;
    end else begin
      wr_pulse_o <= 1'b0;
      if (tck_rise) begin
        // Test-Logic-Reset drops the instruction and the chain selection
        if (state_reg == S_RESET) begin
          ir_reg    <= `TMJA_IR_BYPASS;
          chain_reg <= `TMJA_CHAIN_RESET;
        end
        case (state_reg)
          S_CAPIR: ir_sh_reg <= `TMJA_IR_CAPTURE;
          S_SHIR:  ir_sh_reg <= {tdi_s, ir_sh_reg[`TMJA_IR_W-1:1]};
          S_UPIR:  ir_reg    <= ir_sh_reg;
          S_CAPDR: begin
            byp_reg <= 1'b0;
            // Pending read answer goes into the data field; shifting data out
            if (trace_sel && rd_pend_reg) begin
              dr_reg[`TMJA_DATA_MSB:`TMJA_DATA_LSB] <= rd_data;
              rd_pend_reg <= 1'b0;
            end
          end
          S_SHDR: begin
            byp_reg <= tdi_s;
            if (scan_sel) begin
              chain_sh_reg <= {tdi_s, chain_sh_reg[`TMJA_CHAIN_W-1:1]};
            end
            if (trace_sel) begin
              dr_reg <= {tdi_s, dr_reg[`TMJA_DR_W-1:1]};
            end
          end
          S_UPDR: begin
            if (scan_sel) begin
              chain_reg <= chain_sh_reg;
            end
          end
          default: begin
          end
        endcase
        // Access fires once, on the edge that enters Update-DR
        if (enter_upd && trace_sel) begin
          if (is_write) begin
            wr_pulse_o <= 1'b1;
            wr_addr_o  <= dr_addr;
            wr_data_o  <= dr_reg[`TMJA_DATA_MSB:`TMJA_DATA_LSB];
          end else begin
            // Data field is dropped on reads; only the address is kept
            rd_addr_reg <= dr_addr;
            rd_pend_reg <= 1'b1;
          end
        end
      end
    end
  end

  // Data out moves on the falling test clock so the host, sampling on the
  // rising edge, always finds a settled bit
  always @(posedge clock_i) begin
    if (!rst_n_i || !trst_n_s) begin
      tdo_o      <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end else if (tck_fall) begin
      case (state_reg)
        S_SHIR: begin
          tdo_o      <= ir_sh_reg[0];
          tdo_oe_n_o <= 1'b0;
        end
        S_SHDR: begin
          tdo_o      <= dr_out_bit;
          tdo_oe_n_o <= 1'b0;
        end
        default: begin
          tdo_oe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // Read data come out of a register; the address set at Update-DR has
  // settled long before the next Capture-DR needs it
  tmja_regfile u_regfile (
    .clock_i   (clock_i),
    .wr_en_i   (wr_pulse_o),
    .wr_addr_i (wr_addr_o),
    .wr_data_i (wr_data_o),
    .rd_addr_i (rd_addr_reg),
    .rd_data_o (rd_data)
  );
endmodule // tmja_jtag_access

/* File: tmja_jtag_host.sv */
// JTAG host model that drives the test access port pins
`timescale 1ns/1ps
module tmja_jtag_host (
  output reg  tck_o,
  output reg  tms_o,
  output reg  tdi_o,
  input  wire tdo_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // Pins change at the falling test clock edge; the test clock stays low between ticks
  task tick(input t, input d, output q);
    begin
      tms_o = t;
      tdi_o = d;
      #62.5;
      q = tdo_i;
      tck_o = 1'b1;
      #62.5;
      tck_o = 1'b0;
    end
  endtask
  // Outside a shift the data line toggles so a stale bit is never mistaken for a driven one
  task scan(input ir, input integer n, input [39:0] v, output [39:0] q);
    integer i;
    reg     b;
    begin
      q = 40'h0;
      tick(1'b1, ~tdi_o, b);
      if (ir) begin
        tick(1'b1, ~tdi_o, b);
      end
      tick(1'b0, ~tdi_o, b);
      tick(1'b0, ~tdi_o, b);
      for (i = 0; i < n; i = i + 1) begin
        tick(i == n - 1, v[i], q[i]);
      end
      tick(1'b1, ~tdi_o, b);
      tick(1'b0, ~tdi_o, b);
    end
  endtask
  task cmd(input rw, input [6:0] a, input [31:0] d, output [39:0] q);
    begin
      scan(1'b0, 40, {rw, a, d}, q);
    end
  endtask
endmodule // tmja_jtag_host

/* File: tmja_jtag_access_asserts.sv */
// Port checker for the trace register JTAG access block
`timescale 1ns/1ps
module tmja_jtag_access_asserts (
  input wire        clock_i,
  input wire        rst_n_i,
  input wire        trst_n_i,
  input wire        tck_i,
  input wire        tms_i,
  input wire        tdo_o,
  input wire        tdo_oe_n_o,
  input wire        wr_pulse_o,
  input wire [6:0]  wr_addr_o,
  input wire [31:0] wr_data_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i || !trst_n_i);
  property p_pulse_gap; wr_pulse_o |=> !wr_pulse_o [*8]; endproperty
  a_pulse_gap: assert property (p_pulse_gap) else $error("write pulses too close");
  property p_pulse_upd; wr_pulse_o |-> tck_i && tms_i; endproperty
  a_pulse_upd: assert property (p_pulse_upd) else $error("write outside update entry");
  property p_data_hold; $changed(wr_data_o) |-> wr_pulse_o; endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data moved without a write");
  property p_addr_hold; $changed(wr_addr_o) |-> wr_pulse_o; endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("write address moved without a write");
  property p_tdo_fall; $changed(tdo_o) |-> !tck_i; endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("data out moved while test clock high");
  property p_oe_fall; $changed(tdo_oe_n_o) |-> !tck_i; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("data out enable moved while test clock high");
endmodule // tmja_jtag_access_asserts
bind tmja_jtag_access tmja_jtag_access_asserts i_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .trst_n_i(trst_n_i), .tck_i(tck_i), .tms_i(tms_i), .tdo_o(tdo_o),
  .tdo_oe_n_o(tdo_oe_n_o), .wr_pulse_o(wr_pulse_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));

/* File: testbench.sv */
// Self-checking bench for the trace register JTAG access block
`timescale 1ns/1ps
module testbench;
  reg         clock_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg         trst_n = 1'b1;
  wire        tck, tms, tdi, tdo, tdo_oe_n, wr_pulse;
  wire [6:0]  wr_addr;
  wire [31:0] wr_data;
  reg  [39:0] q;
  integer     n_mismatch = 0;
  integer     n_checks = 0;
  integer     n_pulse = 0;
  initial forever #5 clock_i = ~clock_i;
  always @(posedge clock_i) if (wr_pulse === 1'b1) n_pulse <= n_pulse + 1;
  tmja_jtag_host i_tmja_jtag_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  tmja_jtag_access i_tmja_jtag_access (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
    .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .wr_pulse_o(wr_pulse), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  task check(input [39:0] got, input [39:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task sel_chain(input [3:0] c);
    begin
      i_tmja_jtag_host.scan(1'b1, 4, 40'h2, q);
      check(q, 40'h1);
      i_tmja_jtag_host.scan(1'b0, 4, {36'h0, c}, q);
      i_tmja_jtag_host.scan(1'b1, 4, 40'hc, q);
      check(q, 40'h1);
    end
  endtask
  task t_write_read(input [6:0] a, input [31:0] d);
    integer p;
    begin
      p = n_pulse;
      i_tmja_jtag_host.cmd(1'b1, a, d, q);
      check(40'(n_pulse - p), 40'h1);
      check({1'b0, wr_addr, wr_data}, {1'b0, a, d});
      check({39'h0, tdo_oe_n}, 40'h1);
      i_tmja_jtag_host.cmd(1'b0, a, ~d, q);
      check(40'(n_pulse - p), 40'h1);
      check({8'h0, wr_data}, {8'h0, d});
      i_tmja_jtag_host.cmd(1'b0, a, 32'h0, q);
      check({8'h0, q[31:0]}, {8'h0, d});
    end
  endtask
  task t_other_chain;
    integer p;
    begin
      sel_chain(4'h3);
      p = n_pulse;
      i_tmja_jtag_host.cmd(1'b1, 7'h11, 32'h1234_5678, q);
      check(40'(n_pulse - p), 40'h0);
      sel_chain(4'h6);
    end
  endtask
  // A mid-run TAP reset drops the chain selection and clears the write outputs
  task t_tap_reset;
    integer p;
    begin
      @(negedge clock_i);
      trst_n = 1'b0;
      repeat (8) @(negedge clock_i);
      trst_n = 1'b1;
      repeat (4) @(negedge clock_i);
      check({tdo_oe_n, wr_addr, wr_data}, 40'h80_0000_0000);
      #1.25;
      i_tmja_jtag_host.tick(1'b0, 1'b0, q[0]);
      p = n_pulse;
      i_tmja_jtag_host.cmd(1'b1, 7'h22, 32'hdead_beef, q);
      check(40'(n_pulse - p), 40'h0);
      sel_chain(4'h6);
    end
  endtask
  initial begin
    repeat (16) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    // Offset keeps test clock edges clear of system clock edges
    #1.25;
    i_tmja_jtag_host.tick(1'b0, 1'b0, q[0]);
    sel_chain(4'h6);
    t_write_read(7'h05, 32'ha5c3_0f01);
    t_write_read(7'h7f, 32'hffff_0000);
    t_other_chain;
    t_tap_reset;
    t_write_read(7'h00, 32'h0000_0001);
    tally_and_finish;
  end
  // About 23 scans of at most 45 ticks each fit well inside this span
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
endmodule // testbench
